// *** logic/poh_cfg_if.sv ***
// Purpose: Carries stored register contents to the decoder and decoded settings back.
// Assumes: Both ends run on the same clock.
// Notes:   The bank owns the register side, the decoder owns the decoded side.
`timescale 1ns/1ps
interface poh_cfg_if;
    logic [7:0]          cond;        // Port 4 conditioning byte.
    logic                hp_invert;   // Source hot-plug polarity bit.
    logic [3:0]          sinks;       // Live sink hot-plug inputs.
    logic                detect_en;   // Connection detection enable.
    logic                double_term; // Double-termination drive selected.
    poh_pkg::poh_preemp_t preemp;     // Decoded pre-emphasis level.
    logic                high_swing;  // 750 mVpp swing forced by 6 dB.
    poh_pkg::poh_swing_t swing;       // Decoded swing adjustment.
    poh_pkg::poh_slew_t  slew;        // Decoded slew adjustment.
    logic                src_hp;      // Source hot-plug level.
    logic [3:0]          port_active; // Per-port active state.
    logic                term_on;     // Input termination enabled.

    // Register bank side.
    modport bank (output cond, hp_invert, sinks, detect_en,
                  input double_term, preemp, high_swing, swing, slew, src_hp,
                  port_active, term_on);
    // Decoder side.
    modport dec (input cond, hp_invert, sinks, detect_en,
                 output double_term, preemp, high_swing, swing, slew, src_hp,
                 port_active, term_on);
endinterface

// *** logic/poh_decode.sv ***
// Purpose: Turns the stored bytes and sink inputs into conditioning and hot-plug levels.
// Assumes: Pure combinational; the top registers every result.
// Notes:   The source hot-plug follows the OR of the four sink inputs.
`timescale 1ns/1ps
module poh_decode (
    // Register contents in, decoded settings out.
    poh_cfg_if.dec cfg
);

    ////////////////////////////////////////////////////////////////////////////////
    // Output driver conditioning.
    always_comb begin
        // Mode bit picks double termination when set.
        cfg.double_term = cfg.cond[poh_pkg::COND_MODE_BIT];
        // Any value with the top bit set means 6 dB at the wider swing.
        cfg.high_swing  = cfg.cond[poh_pkg::COND_PE_MSB];
        if (cfg.cond[poh_pkg::COND_PE_MSB]) begin
            cfg.preemp = poh_pkg::PE_6DB;
        end else begin
            cfg.preemp = poh_pkg::poh_preemp_t'({1'b0,
                cfg.cond[poh_pkg::COND_PE_MSB-1:poh_pkg::COND_PE_LSB]});
        end
        // Swing codes map one to one onto the adjustment steps.
        cfg.swing = poh_pkg::poh_swing_t'(
            cfg.cond[poh_pkg::COND_SW_MSB:poh_pkg::COND_SW_LSB]);
        // Slew codes 01 and 10 share the +5% step.
        unique case (cfg.cond[poh_pkg::COND_SL_MSB:poh_pkg::COND_SL_LSB])
            2'h0: cfg.slew = poh_pkg::SL_NOMINAL;
            2'h1,
            2'h2: cfg.slew = poh_pkg::SL_PLUS5;
            2'h3: cfg.slew = poh_pkg::SL_PLUS10;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hot-plug forwarding and connection detection.
    always_comb begin
        // Polarity bit set gives the inverse of the sink state.
        cfg.src_hp = (|cfg.sinks) ^ cfg.hp_invert;
        // With detection off every port stays active and termination stays on.
        cfg.port_active = cfg.detect_en ? cfg.sinks : 4'hf;
        cfg.term_on     = !cfg.detect_en || (|cfg.sinks);
    end

endmodule

// *** logic/poh_pkg.sv ***
// Purpose: Constants for the port-4 output conditioning and hot-plug register bank.
// Assumes: Byte-wide registers reached over the two-wire serial control bus.
// Notes:   Every offset, field position, reset value and code is named here once.
// Notes on behaviour
// - Bit 7 selects open-drain or double-termination drive.
// - Bits 6:4 pick pre-emphasis; 1xx means 6 dB.
// - Bits 3:2 adjust swing around nominal 500 mV.
// - Bits 1:0 adjust slew: nominal, +5%, +10%.
// - Hot-plug bit 7 inverts the source hot-plug output.
// - Hot-plug bits 3:0 show live sink inputs, read-only.
// - With detection on, unplugged ports idle; termination off once no sink is plugged.
package poh_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] OFF_PORT4_COND   = 8'h05; // Port 4 output conditioning.
    localparam logic [7:0] OFF_HOTPLUG      = 8'h06; // Hot-plug control and status.
    localparam logic [7:0] OFF_RESERVED     = 8'h07; // Reserved spare byte.
    localparam logic [7:0] RST_PORT4_COND   = 8'h00; // Power-up value of conditioning.
    localparam logic       RST_HP_INVERT    = 1'h0;  // Power-up value of the invert bit.

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int COND_MODE_BIT   = 7; // Driver mode bit.
    localparam int COND_PE_MSB     = 6; // Pre-emphasis field, top bit.
    localparam int COND_PE_LSB     = 4; // Pre-emphasis field, bottom bit.
    localparam int COND_SW_MSB     = 3; // Swing field, top bit.
    localparam int COND_SW_LSB     = 2; // Swing field, bottom bit.
    localparam int COND_SL_MSB     = 1; // Slew field, top bit.
    localparam int COND_SL_LSB     = 0; // Slew field, bottom bit.
    localparam int HP_INVERT_BIT   = 7; // Source hot-plug polarity bit.
    localparam int NUM_SINKS       = 4; // Sink hot-plug inputs, bits 3:0.

    ////////////////////////////////////////////////////////////////////////////////
    // Serial bus framing.
    localparam logic [2:0] DEV_ADDR_HI    = 3'h5;  // Fixed upper address bits 101.
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;  // Data bits before an acknowledge.

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded settings.
    typedef enum logic [2:0] {PE_0DB, PE_1P5DB, PE_2P5DB, PE_3P5DB, PE_6DB} poh_preemp_t;
    typedef enum logic [1:0] {SW_NOMINAL, SW_MINUS10, SW_PLUS10, SW_PLUS20} poh_swing_t;
    typedef enum logic [1:0] {SL_NOMINAL, SL_PLUS5, SL_PLUS10} poh_slew_t;

endpackage

// *** logic/poh_regbank.sv ***
// Purpose: Serial-bus slave holding the port 4 conditioning and hot-plug bytes.
// Assumes: SCL and SDA are synchronous to MCLK and much slower than it.
// Notes:   SDA is open drain; SDA_OE high pulls the line low.
`timescale 1ns/1ps
module poh_regbank (
    // Clock and reset.
    input  wire logic       MCLK,
    input  wire logic       RST,
    // Serial control bus.
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output wire logic       SDA_OUT,
    output wire logic       SDA_OE,
    input  wire logic [3:0] I2C_ADR,
    // Hot-plug pins and detection control.
    input  wire logic [3:0] SINK_HOTPLUG_INPUTS,
    input  wire logic       CONN_DETECT_EN,
    output logic            SOURCE_HOTPLUG_OUTPUT,
    // Port 4 driver conditioning.
    output logic            DRIVER_DOUBLE_TERM,
    output logic [2:0]      PREEMP_LEVEL,
    output logic            PREEMP_HIGH_SWING,
    output logic [1:0]      SWING_ADJUST,
    output logic [1:0]      SLEW_ADJUST,
    // Port activity and input termination.
    output logic [3:0]      PORT_ACTIVE,
    output logic            INPUT_TERM_ON
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_OFFS, ST_OFFS_ACK,
                  ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK} poh_state_t;

    poh_state_t  state_q;      // Transfer state.
    logic        scl_q;        // Previous SCL sample, for edges.
    logic        sda_q;        // Previous SDA sample, for edges.
    logic [7:0]  shift_q;      // Receive and transmit shift register.
    logic [3:0]  cnt_q;        // Bits moved in the current byte.
    logic [7:0]  ptr_q;        // Register offset pointer.
    logic        rw_q;         // Direction bit of the address byte.
    logic        mack_q;       // Host acknowledged the last read byte.
    logic        oe_q;         // Pulling SDA low.
    logic [7:0]  cond_q;       // Port 4 conditioning register.
    logic        hp_inv_q;     // Source hot-plug polarity bit.
    logic        scl_rise;     // SCL rising edge.
    logic        scl_fall;     // SCL falling edge.
    logic        start_cond;   // SDA falls with SCL high.
    logic        stop_cond;    // SDA rises with SCL high.
    logic [7:0]  rd_byte;      // Byte a read would send now, status bits live.
    poh_cfg_if   cfg ();       // Link to the decoder.

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode, used for the first byte and for every following one.
    function automatic logic [7:0] read_reg(input logic [7:0] off, input logic [7:0] cond,
                                            input logic inv, input logic [3:0] sinks);
        logic [7:0] val;
        val = 8'h00;
        if (off == poh_pkg::OFF_PORT4_COND) begin
            val = cond;
        end else if (off == poh_pkg::OFF_HOTPLUG) begin
            // Reserved bits 6:4 read zero; sink bits are sampled live.
            val = {inv, 3'h0, sinks};
        end
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus edge and framing detection.
    assign scl_rise   = SCL_IN && !scl_q;
    assign scl_fall   = !SCL_IN && scl_q;
    assign start_cond = SCL_IN && scl_q && sda_q && !SDA_IN;
    assign stop_cond  = SCL_IN && scl_q && !sda_q && SDA_IN;

    // One shared read decode; its top bit also sets the first driven level.
    assign rd_byte = read_reg(ptr_q, cond_q, hp_inv_q, SINK_HOTPLUG_INPUTS);

    // Keep the previous pin levels; idle bus is high.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= SCL_IN;
            sda_q <= SDA_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing: sample on SCL rise, change SDA on SCL fall.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            mack_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else if (start_cond) begin
            // A start, repeated or not, always begins a new address byte.
            state_q <= ST_ADDR;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end else if (stop_cond) begin
            // A stop frees the line and ends the transfer.
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
        end else if (scl_rise) begin
            // Receive states shift in data; the read acknowledge is sampled here.
            unique case (state_q)
                ST_ADDR, ST_OFFS, ST_WDATA: begin
                    shift_q <= {shift_q[6:0], SDA_IN};
                    cnt_q   <= cnt_q + 4'h1;
                end
                ST_RDATA_ACK: mack_q <= !SDA_IN;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                ST_IDLE: ;
                ST_ADDR: if (cnt_q == poh_pkg::BITS_PER_BYTE) begin
                    // Answer only our own address.
                    if (shift_q[7:1] == {poh_pkg::DEV_ADDR_HI, I2C_ADR}) begin
                        state_q <= ST_ADDR_ACK;
                        rw_q    <= shift_q[0];
                        oe_q    <= 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_q <= 4'h0;
                    if (rw_q) begin
                        // Read continues from the current pointer.
                        shift_q <= rd_byte;
                        oe_q    <= !rd_byte[7];
                        cnt_q   <= 4'h1;
                        state_q <= ST_RDATA;
                    end else begin
                        oe_q    <= 1'b0;
                        state_q <= ST_OFFS;
                    end
                end
                ST_OFFS: if (cnt_q == poh_pkg::BITS_PER_BYTE) begin
                    ptr_q   <= shift_q;
                    oe_q    <= 1'b1;
                    state_q <= ST_OFFS_ACK;
                end
                ST_WDATA: if (cnt_q == poh_pkg::BITS_PER_BYTE) begin
                    // Data byte lands at the pointer, which then steps on.
                    ptr_q   <= ptr_q + 8'h01;
                    oe_q    <= 1'b1;
                    state_q <= ST_WDATA_ACK;
                end
                ST_OFFS_ACK, ST_WDATA_ACK: begin
                    cnt_q   <= 4'h0;
                    oe_q    <= 1'b0;
                    state_q <= ST_WDATA;
                end
                ST_RDATA: if (cnt_q == poh_pkg::BITS_PER_BYTE) begin
                    // Release the line for the host's acknowledge.
                    oe_q    <= 1'b0;
                    ptr_q   <= ptr_q + 8'h01;
                    state_q <= ST_RDATA_ACK;
                end else begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    oe_q    <= !shift_q[6];
                    cnt_q   <= cnt_q + 4'h1;
                end
                ST_RDATA_ACK: if (mack_q) begin
                    shift_q <= rd_byte;
                    oe_q    <= !rd_byte[7];
                    cnt_q   <= 4'h1;
                    state_q <= ST_RDATA;
                end else begin
                    // No acknowledge ends the read; wait for stop.
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes, taken when a data byte completes.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cond_q   <= poh_pkg::RST_PORT4_COND;
            hp_inv_q <= poh_pkg::RST_HP_INVERT;
        end else if (scl_fall && !start_cond && !stop_cond && state_q == ST_WDATA
                     && cnt_q == poh_pkg::BITS_PER_BYTE) begin
            if (ptr_q == poh_pkg::OFF_PORT4_COND) begin
                cond_q <= shift_q;
            end else if (ptr_q == poh_pkg::OFF_HOTPLUG) begin
                // Only the polarity bit is stored; status and reserved bits drop.
                hp_inv_q <= shift_q[poh_pkg::HP_INVERT_BIT];
            end
            // Reserved and unmapped offsets take no write.
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoder and registered outputs.
    assign cfg.cond      = cond_q;
    assign cfg.hp_invert = hp_inv_q;
    assign cfg.sinks     = SINK_HOTPLUG_INPUTS;
    assign cfg.detect_en = CONN_DETECT_EN;
    assign SDA_OUT       = 1'b0;
    assign SDA_OE        = oe_q;

    poh_decode u_decode (
        .cfg (cfg.dec)
    );

    // Every pin-level result is registered once after decoding.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DRIVER_DOUBLE_TERM    <= 1'b0;
            PREEMP_LEVEL          <= 3'h0;
            PREEMP_HIGH_SWING     <= 1'b0;
            SWING_ADJUST          <= 2'h0;
            SLEW_ADJUST           <= 2'h0;
            SOURCE_HOTPLUG_OUTPUT <= 1'b0;
            PORT_ACTIVE           <= 4'h0;
            INPUT_TERM_ON         <= 1'b0;
        end else begin
            DRIVER_DOUBLE_TERM    <= cfg.double_term;
            PREEMP_LEVEL          <= cfg.preemp;
            PREEMP_HIGH_SWING     <= cfg.high_swing;
            SWING_ADJUST          <= cfg.swing;
            SLEW_ADJUST           <= cfg.slew;
            SOURCE_HOTPLUG_OUTPUT <= cfg.src_hp;
            PORT_ACTIVE           <= cfg.port_active;
            INPUT_TERM_ON         <= cfg.term_on;
        end
    end

endmodule

// *** verification/poh_host_model.sv ***
// Purpose: Serial-bus host that writes and reads the bank byte by byte.
// Assumes: SDA has a pull-up; every level is held 4 MCLK.
// Notes:   The serial clock stands high between frames.
`timescale 1ns/1ps
module poh_host_model (
    // Clock.
    input  wire logic MCLK,
    // Serial bus.
    input  wire logic SDA_OE,
    output logic      SCL_IN,
    output wire logic SDA_IN
);
    logic sda_q; // Host's own data level; 1 releases the line.
    // Wired-AND with the pull-up: either party pulling low wins.
    assign SDA_IN = sda_q & ~SDA_OE;
    initial begin
        SCL_IN = 1'b1;
        sda_q  = 1'b1;
    end
    // Change both lines just after an edge, then hold them.
    task automatic drv(input logic c, input logic d);
        @(posedge MCLK);
        SCL_IN <= c;
        sda_q  <= d;
        repeat (3) @(posedge MCLK);
    endtask
    // One bit: set data with clock low, sample the wire at the high phase.
    task automatic bit_io(input logic d, output logic q);
        drv(1'b0, d);
        drv(1'b1, d);
        q = SDA_IN;
        drv(1'b0, d);
    endtask
    task automatic start();
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
        drv(1'b0, 1'b0);
    endtask
    task automatic stop();
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
    endtask
    // Eight bits most significant first, then the acknowledge bit.
    task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ai, ack);
    endtask
    task automatic write_reg(input logic [3:0] a, input logic [7:0] o, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        start();
        byte_io({poh_pkg::DEV_ADDR_HI, a, 1'b0}, 1'b1, q, k[0]);
        byte_io(o, 1'b1, q, k[1]);
        byte_io(d, 1'b1, q, k[2]);
        stop();
        ok = (k === 3'h0);
    endtask
    // Offset set by a write, then a repeated start and a single read byte.
    task automatic read_reg(input logic [3:0] a, input logic [7:0] o, output logic [7:0] d,
                            output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        start();
        byte_io({poh_pkg::DEV_ADDR_HI, a, 1'b0}, 1'b1, q, k[0]);
        byte_io(o, 1'b1, q, k[1]);
        start();
        byte_io({poh_pkg::DEV_ADDR_HI, a, 1'b1}, 1'b1, q, k[2]);
        byte_io(8'hff, 1'b1, d, q[0]);
        stop();
        ok = (k === 3'h0);
    endtask
    // Two bytes in one read: the host acknowledges the first, then ends the second.
    task automatic read_two(input logic [3:0] a, input logic [7:0] o, output logic [15:0] d,
                            output logic ok);
        logic [7:0] q;
        logic [3:0] k;
        start();
        byte_io({poh_pkg::DEV_ADDR_HI, a, 1'b0}, 1'b1, q, k[0]);
        byte_io(o, 1'b1, q, k[1]);
        start();
        byte_io({poh_pkg::DEV_ADDR_HI, a, 1'b1}, 1'b1, q, k[2]);
        byte_io(8'hff, 1'b0, d[15:8], k[3]);
        byte_io(8'hff, 1'b1, d[7:0], q[0]);
        stop();
        ok = (k === 4'h0);
    endtask
endmodule

// *** verification/poh_regbank_sva.sv ***
// Purpose: Port-level assertions for the port 4 conditioning and hot-plug bank.
// Assumes: One clock domain; the serial clock is slow and held at least 4 MCLK a level.
// Notes:   Outputs are registered, so each output-to-input relation looks at least one sample back.
`timescale 1ns/1ps
module poh_regbank_sva (
    // Clock and reset.
    input wire logic       MCLK,
    input wire logic       RST,
    // Serial bus.
    input wire logic       SCL_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    // Hot-plug and detection.
    input wire logic [3:0] SINK_HOTPLUG_INPUTS,
    input wire logic       CONN_DETECT_EN,
    input wire logic       SOURCE_HOTPLUG_OUTPUT,
    // Conditioning and activity.
    input wire logic [2:0] PREEMP_LEVEL,
    input wire logic       PREEMP_HIGH_SWING,
    input wire logic [1:0] SLEW_ADJUST,
    input wire logic [3:0] PORT_ACTIVE,
    input wire logic       INPUT_TERM_ON
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    // Three clean samples after reset, so registered outputs mirror live inputs.
    sequence s_settled;
        !$past(RST) && !$past(RST, 2) && !$past(RST, 3);
    endsequence
    // Serial clock idle high long enough that no register write is in flight.
    sequence s_scl_idle;
        SCL_IN [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // A change in the OR of the sinks flips the source level, whatever the polarity bit holds.
    a_srchp_follows: assert property (s_scl_idle ##1 s_settled |->
        (SOURCE_HOTPLUG_OUTPUT ^ $past(SOURCE_HOTPLUG_OUTPUT)) ==
        ((|$past(SINK_HOTPLUG_INPUTS)) ^ (|$past(SINK_HOTPLUG_INPUTS, 2))))
        else $error("source hot-plug did not track the sinks");
    a_port_active: assert property (s_settled |-> PORT_ACTIVE ==
        ($past(CONN_DETECT_EN) ? $past(SINK_HOTPLUG_INPUTS) : 4'hf))
        else $error("port activity wrong");
    a_term_on: assert property (s_settled |-> INPUT_TERM_ON ==
        !($past(CONN_DETECT_EN) && $past(SINK_HOTPLUG_INPUTS) == 4'h0))
        else $error("input termination wrong");
    a_high_swing: assert property (
        PREEMP_HIGH_SWING == (PREEMP_LEVEL == 3'h4))
        else $error("high swing not tied to the 6 dB level");
    a_preemp_range: assert property (PREEMP_LEVEL <= 3'h4)
        else $error("pre-emphasis level out of range");
    a_slew_range: assert property (SLEW_ADJUST != 2'h3)
        else $error("slew code out of range");
    // The data pin is open drain, so the driven value is always low.
    a_sda_low: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    // The pull-down only moves shortly after a serial clock fall.
    a_oe_at_fall: assert property ($changed(SDA_OE) |-> !$past(SCL_IN) &&
        ($past(SCL_IN, 2) || $past(SCL_IN, 3) || $past(SCL_IN, 4)))
        else $error("data enable moved away from a clock fall");
    a_oe_stands: assert property (SCL_IN [*3] |=> $stable(SDA_OE))
        else $error("data enable moved while clock high");
endmodule
bind poh_regbank poh_regbank_sva u_sva (.MCLK, .RST, .SCL_IN, .SDA_OUT, .SDA_OE,
    .SINK_HOTPLUG_INPUTS, .CONN_DETECT_EN, .SOURCE_HOTPLUG_OUTPUT, .PREEMP_LEVEL,
    .PREEMP_HIGH_SWING, .SLEW_ADJUST, .PORT_ACTIVE, .INPUT_TERM_ON);

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the conditioning and hot-plug register bank.
// Assumes: Host model drives the serial bus; the bench drives the hot-plug pins.
// Notes:   Corner codes are built from the loop index, the rest drawn from a fixed seed.
`timescale 1ns/1ps
module testbench;
    logic            MCLK = 1'b0;
    logic            RST  = 1'b1;
    logic [3:0]      adr, sinks;
    logic            det, ok;
    logic [7:0]      rd, v, keep;
    logic [15:0]     two;
    wire logic       scl, sda, sda_out, sda_oe, src_hp, dterm, hswing, term;
    wire logic [2:0] pe;
    wire logic [1:0] sw, sl;
    wire logic [3:0] act;
    int              n_mismatch = 0;
    int              num_checks = 0;
    int              cyc        = 0;
    always #12.5 MCLK = ~MCLK;
    poh_host_model i_host (.MCLK(MCLK), .SDA_OE(sda_oe), .SCL_IN(scl), .SDA_IN(sda));
    poh_regbank i_dut (.MCLK(MCLK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .I2C_ADR(adr), .SINK_HOTPLUG_INPUTS(sinks),
        .CONN_DETECT_EN(det), .SOURCE_HOTPLUG_OUTPUT(src_hp), .DRIVER_DOUBLE_TERM(dterm),
        .PREEMP_LEVEL(pe), .PREEMP_HIGH_SWING(hswing), .SWING_ADJUST(sw),
        .SLEW_ADJUST(sl), .PORT_ACTIVE(act), .INPUT_TERM_ON(term));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected {mode, pre-emphasis, high swing, swing, slew} for a written byte.
    function automatic logic [8:0] cond_exp(input logic [7:0] c);
        logic [1:0] s;
        s = (c[1:0] == 2'h3) ? 2'h2 : {1'b0, |c[1:0]};
        return {c[7], c[6] ? 3'h4 : {1'b0, c[5:4]}, c[6], c[3:2], s};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        rd    = 8'($urandom(94));
        adr   = 4'($urandom);
        sinks = 4'h0;
        det   = 1'b0;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        for (int o = 5; o < 8; o++) begin
            i_host.read_reg(adr, 8'(o), rd, ok);
            chk({ok, rd}, {1'b1, 8'h00});
        end
        $display("test power-up values done");
        // Every mode, pre-emphasis, swing and slew code, then random bytes.
        for (int i = 0; i < 10; i++) begin
            v = (i < 8) ? {i[0], i[2:0], i[1:0], i[2:1]} : 8'($urandom);
            i_host.write_reg(adr, 8'h05, v, ok);
            chk({dterm, pe, hswing, sw, sl}, cond_exp(v));
            i_host.read_reg(adr, 8'h05, rd, ok);
            chk({ok, rd}, {1'b1, v});
        end
        keep = v;
        $display("test conditioning done");
        // Both polarities, detection on and off, no sink and random sinks.
        for (int i = 0; i < 8; i++) begin
            i_host.write_reg(adr, 8'h06, {i[0], 7'h7f}, ok);
            @(posedge MCLK);
            sinks <= (i[2:1] == 2'h1) ? 4'h0 : 4'($urandom);
            det   <= i[1];
            repeat (3) @(posedge MCLK);
            #1;
            chk(src_hp, (|sinks) ^ i[0]);
            chk({act, term}, {det ? sinks : 4'hf, !(det && sinks == 4'h0)});
            i_host.read_reg(adr, 8'h06, rd, ok);
            chk(rd, {i[0], 3'h0, sinks});
        end
        $display("test hot-plug done");
        // Reserved byte ignored; a foreign address is not acknowledged.
        i_host.write_reg(adr, 8'h07, 8'($urandom), ok);
        i_host.read_reg(adr, 8'h07, rd, ok);
        chk({ok, rd}, {1'b1, 8'h00});
        i_host.write_reg(~adr, 8'h05, ~keep, ok);
        chk(ok, 1'b0);
        i_host.read_reg(adr, 8'h05, rd, ok);
        chk(rd, keep);
        // Pointer steps from conditioning to hot-plug inside one acknowledged read.
        i_host.read_two(adr, 8'h05, two, ok);
        chk({ok, two[15:8]}, {1'b1, keep});
        chk(two[7:0], {1'b1, 3'h0, sinks});
        $display("test refusals done");
        complete_run();
    end
endmodule
